// >>> common/usp_pkg.sv
// constants and types shared by the master spi serial unit
package usp_pkg;
  localparam logic [1:0] MODE_SPI_MASTER = 2'h3;
  localparam int         DIV_WIDTH       = 12;
  localparam int         FRAME_BITS      = 8;
  localparam logic [3:0] LAST_EDGE       = 4'hf;
  localparam logic [3:0] EDGE_CNT_RESET  = 4'h0;
  localparam logic [11:0] DIV_RESET      = 12'h000;
  localparam logic [11:0] HALF_CNT_RESET = 12'h000;
  localparam logic [11:0] HALF_CNT_STEP  = 12'h001;
  localparam logic       IDLE_LINE       = 1'b1;
  localparam int         TX_FIFO_DEPTH   = 16;
  localparam int         RX_BUF_DEPTH    = 2;
  localparam logic [1:0] RX_COUNT_EMPTY  = 2'h0;
  localparam logic [1:0] RX_COUNT_FULL   = 2'h2;
  localparam logic [1:0] RX_COUNT_STEP   = 2'h1;

  // control fields written by software
  typedef struct packed {
    logic [1:0] mode_select_bits;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic       data_order_bit;
  } usp_cfg_type;

  typedef enum logic {
    USP_IDLE,
    USP_SHIFT
  } usp_state_type;
endpackage : usp_pkg

// >>> test/usart_master_spi_mode_bench.sv
// self-checking bench for the spi master serial unit
`timescale 1ns/1ps
`default_nettype none
module usart_master_spi_mode_bench
  import usp_pkg::*;
;
  logic        clk, reset, tx_en, rx_en, pin_dir, div_we, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, tc_flag, tc_clear, spi_mode, fe, ov, pe;
  logic        sck, sck_oe, mosi, mosi_oe, miso, got_valid;
  usp_cfg_type cfg;
  logic [11:0] div_wdata, baud_divisor;
  logic [7:0]  tx_data, rx_data, got_data;
  logic [7:0]  exp_rx[$], exp_got[$];
  int          num_errors = 0, n_checks = 0, cycles = 0, nframes = 0, got_cnt = 0;
  integer      seed = 32'ha06d;

  usp_master dut (.clk(clk), .reset(reset), .cfg(cfg), .transmitter_enable_bit(tx_en),
    .receiver_enable_bit(rx_en), .clock_pin_direction(pin_dir), .baud_divisor_we(div_we),
    .baud_divisor_wdata(div_wdata), .baud_divisor(baud_divisor), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .transmit_complete_flag(tc_flag), .transmit_complete_clear(tc_clear),
    .master_spi_mode(spi_mode), .frame_error_flag(fe), .overrun_flag(ov),
    .parity_error_flag(pe), .transfer_clock_pin_out(sck), .transfer_clock_pin_oe(sck_oe),
    .serial_data_out(mosi), .serial_data_oe(mosi_oe), .serial_data_in(miso));

  usp_slave_model slave (.clk(clk), .reset(reset), .sck(sck), .mosi(mosi),
    .cpol(cfg.clock_polarity_bit), .cpha(cfg.clock_phase_bit), .lsb(cfg.data_order_bit),
    .miso(miso), .got_data(got_data), .got_valid(got_valid));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // result watchers take the oldest note
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check("rx_data", rx_data, exp_rx.size() ? exp_rx.pop_front() : 8'hxx);
    end
    if (got_valid === 1'b1) begin
      got_cnt++;
      check("mosi_byte", got_data, exp_got.size() ? exp_got.pop_front() : 8'hxx);
    end
  end

  // clear flag, then queue n random bytes; keep says how many replies survive
  task automatic xfer(input int n, input int keep);
    logic [7:0] b;
    @(negedge clk);
    tc_clear = 1'b1;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      exp_got.push_back(b);
      if (i < keep) exp_rx.push_back(8'ha5 ^ nframes[7:0]);
      nframes++;
      @(negedge clk);
      if (i == 0) check("flag_clear", tc_flag, 12'h0);
      tc_clear = 1'b0;
      tx_valid = 1'b1;
      tx_data  = b;
      while (tx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : xfer

  // half period and first edge direction
  task automatic measure(input int d);
    logic s;
    int   n;
    s = sck;
    while (sck === s) @(negedge clk);
    check("lead_edge", sck, !cfg.clock_polarity_bit);
    s = sck;
    n = 0;
    while (sck === s) begin
      @(negedge clk);
      n++;
    end
    check("half_period", 12'(n), 12'(d + 1));
  endtask : measure

  task automatic finish_frames;
    while (tc_flag !== 1'b1) @(negedge clk);
    repeat (4) @(negedge clk);
    check("frames_seen", 12'(got_cnt), 12'(nframes));
    check("idle_data", mosi, 12'h1);
    check("idle_clock", sck, cfg.clock_polarity_bit);
  endtask : finish_frames

  initial begin
    int d;
    reset     = 1'b1;
    cfg       = '{2'h0, 1'b0, 1'b0, 1'b0};
    tx_en     = 1'b0;
    rx_en     = 1'b0;
    pin_dir   = 1'b0;
    div_we    = 1'b0;
    div_wdata = 12'h000;
    tx_valid  = 1'b0;
    tx_data   = 8'h00;
    rx_ready  = 1'b1;
    tc_clear  = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check("divisor_reset", baud_divisor, 12'h000);
    check("mode_off", {spi_mode, tx_ready}, 12'h0);
    // pin first, enable with divisor zero
    pin_dir = 1'b1;
    cfg     = '{2'h3, 1'b0, 1'b0, 1'b0};
    tx_en   = 1'b1;
    rx_en   = 1'b1;
    @(negedge clk);
    check("pins_on", {spi_mode, sck_oe, mosi_oe, sck}, 12'he);
    // all four modes in both bit orders
    for (int m = 0; m < 8; m++) begin
      @(negedge clk);
      cfg       = '{2'h3, m[1], m[0], m[2]};
      // receive round trip through the synchroniser needs three
      d         = 3 + ($random(seed) & 3);
      div_we    = 1'b1;
      div_wdata = 12'(d);
      @(negedge clk);
      div_we = 1'b0;
      check("divisor", baud_divisor, 12'(d));
      xfer(2, 2);
      measure(d);
      while (got_cnt != nframes - 1) @(negedge clk);
      check("early_flag", tc_flag, 12'h0);
      finish_frames();
    end
    // reader stalls: third reply is dropped
    rx_ready = 1'b0;
    xfer(3, 2);
    finish_frames();
    check("rx_held", rx_valid, 12'h1);
    check("err_flags", {fe, ov, pe}, 12'h0);
    rx_ready = 1'b1;
    repeat (4) @(negedge clk);
    check("rx_left", 12'(exp_rx.size()), 12'h0);
    // transmitter alone, at the two fastest divisors
    rx_en = 1'b0;
    for (int k = 0; k < 2; k++) begin
      div_we    = 1'b1;
      div_wdata = 12'(k);
      @(negedge clk);
      div_we = 1'b0;
      xfer(2, 0);
      measure(k);
      finish_frames();
    end
    check("rx_off", rx_valid, 12'h0);
    tx_en = 1'b0;
    @(negedge clk);
    check("tx_off", tx_ready, 12'h0);
    stop_test();
  end
endmodule : usart_master_spi_mode_bench
`default_nettype wire

// >>> test/usp_slave_model.sv
// behavioural spi slave on the far side of the master's pins
`timescale 1ns/1ps
`default_nettype none
module usp_slave_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  output logic            miso,
  output logic      [7:0] got_data,
  output logic            got_valid
);
  logic       rel, rel_reg, lead, trail, samp, setp, tog_reg, drive, miso_reg, mosi_d;
  logic [2:0] bitn_reg;
  logic [7:0] frame_reg, sh_reg, rep, sh_next;
  // clock level against idle, so a polarity change makes no edge
  assign rel = sck ^ cpol;
  assign lead  = rel & ~rel_reg;
  assign trail = ~rel & rel_reg;
  assign samp = cpha ? trail : lead;
  assign setp = cpha ? lead : trail;
  assign rep  = 8'ha5 ^ frame_reg;
  // one order both ways; data line as it stood at the clock edge
  assign sh_next = lsb ? {mosi_d, sh_reg[7:1]} : {sh_reg[6:0], mosi_d};
  // undriven line shows a changing pattern
  assign drive = ~cpha | rel | (bitn_reg != 3'h0);
  assign miso  = drive ? miso_reg : tog_reg;
  always_ff @(posedge clk) begin
    rel_reg   <= rel;
    tog_reg   <= ~tog_reg;
    got_valid <= 1'b0;
    mosi_d    <= mosi;
    if (reset) begin
      rel_reg   <= 1'b0;
      tog_reg   <= 1'b0;
      bitn_reg  <= 3'h0;
      frame_reg <= 8'h00;
    end else begin
      if (samp) begin
        sh_reg   <= sh_next;
        bitn_reg <= bitn_reg + 3'h1;
        if (bitn_reg == 3'h7) begin
          got_data  <= sh_next;
          got_valid <= 1'b1;
          frame_reg <= frame_reg + 8'h01;
        end
      end
      if (setp || (bitn_reg == 3'h0 && !rel)) begin
        miso_reg <= lsb ? rep[bitn_reg] : rep[3'h7 - bitn_reg];
      end
    end
  end
endmodule : usp_slave_model
`default_nettype wire

// >>> verilog/usp_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module usp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0]   COUNT_FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST   = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_STEP   = PW'(1);
  localparam logic [PW:0]   COUNT_STEP = (PW+1)'(1);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("usp_fifo depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign in_ready  = (count_reg != COUNT_FULL);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_STEP;
      if (pop)  rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_STEP;
      if (push && !pop) count_reg <= count_reg + COUNT_STEP;
      else if (pop && !push) count_reg <= count_reg - COUNT_STEP;
    end
  end
endmodule : usp_fifo
`default_nettype wire

// >>> verilog/usp_master.sv
// serial unit running as a three-wire spi master
//
// How it works
// - mode bits both one select spi master
// - one shared transfer controller, no parity
// - clock always generated internally, driven out when pin direction set
// - bit clock is clk over 2*(div+1)
// - shift out and sample on opposite edges
// - phase picks sample or setup leading edge
// - polarity zero rising lead, one falling
// - frames are exactly eight data bits
// - one data order for both directions
// - next frame at once, else line high
// - buffered writes, complete after all bytes
// - baud divisor resets to zero
// - transmitter alone runs, receiver needs it
// - pin control same, addresses unchanged
// - data write starts transfer when shifter free
// - read per byte, overflow drops newest
// - framing, overrun, parity flags read zero
`timescale 1ns/1ps
`default_nettype none
module usp_master
  import usp_pkg::*;
#(
  parameter int TX_DEPTH = TX_FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire usp_cfg_type          cfg,
  input  wire logic                 transmitter_enable_bit,
  input  wire logic                 receiver_enable_bit,
  input  wire logic                 clock_pin_direction,
  input  wire logic                 baud_divisor_we,
  input  wire logic [DIV_WIDTH-1:0] baud_divisor_wdata,
  output logic      [DIV_WIDTH-1:0] baud_divisor,
  input  wire logic [FRAME_BITS-1:0] tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output logic      [FRAME_BITS-1:0] rx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic                      transmit_complete_flag,
  input  wire logic                 transmit_complete_clear,
  output logic                      master_spi_mode,
  output logic                      frame_error_flag,
  output logic                      overrun_flag,
  output logic                      parity_error_flag,
  output logic                      transfer_clock_pin_out,
  output logic                      transfer_clock_pin_oe,
  output logic                      serial_data_out,
  output logic                      serial_data_oe,
  input  wire logic                 serial_data_in
);
  generate
    if (TX_DEPTH < 2) begin : g_bad_tx_depth
      $error("usp_master needs a transmit buffer of at least two words");
    end
  endgenerate

  // pick the first bit to send for the chosen order
  function automatic logic first_bit(input logic [FRAME_BITS-1:0] v, input logic lsb);
    first_bit = lsb ? v[0] : v[FRAME_BITS-1];
  endfunction : first_bit

  // move the next bit into the send position
  function automatic logic [FRAME_BITS-1:0] shift_on(input logic [FRAME_BITS-1:0] v,
                                                    input logic lsb);
    shift_on = lsb ? {1'b0, v[FRAME_BITS-1:1]} : {v[FRAME_BITS-2:0], 1'b0};
  endfunction : shift_on

  usp_state_type         state_reg;
  usp_state_type         state_next;
  logic [DIV_WIDTH-1:0]  div_reg;
  logic [DIV_WIDTH-1:0]  half_cnt_reg;
  logic [DIV_WIDTH-1:0]  half_cnt_next;
  logic [3:0]            edge_cnt_reg;
  logic                  sck_phase_reg;
  logic [FRAME_BITS-1:0] tx_sh_reg;
  logic [FRAME_BITS-1:0] rx_sh_reg;
  logic [FRAME_BITS-1:0] rx_sh_next;
  logic                  out_reg;
  logic                  txc_reg;
  logic                  sync1_reg;
  logic                  sync2_reg;
  logic [FRAME_BITS-1:0] rx_buf_reg [RX_BUF_DEPTH];
  logic [1:0]            rx_count_reg;
  logic                  spi_on;
  logic                  edge_now;
  logic                  lead_edge;
  logic                  trail_edge;
  logic                  frame_end;
  logic                  sample_now;
  logic                  setup_now;
  logic                  load_now;
  logic                  txc_set;
  logic                  rx_push;
  logic                  rx_pop;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [FRAME_BITS-1:0] fifo_out_data;

  // mode selection and enable
  assign master_spi_mode = (cfg.mode_select_bits == MODE_SPI_MASTER);
  // transmitter alone may run
  assign spi_on          = master_spi_mode && transmitter_enable_bit;

  // transmit buffer in the data path
  usp_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (tx_valid && spi_on),
    .in_ready  (fifo_in_ready),
    .in_data   (tx_data),
    .out_valid (fifo_out_valid),
    .out_ready (load_now),
    .out_data  (fifo_out_data)
  );
  assign tx_ready = fifo_in_ready && spi_on;

  always_ff @(posedge clk) begin
    if (reset) div_reg <= DIV_RESET;
    else if (baud_divisor_we) div_reg <= baud_divisor_wdata;
  end
  assign baud_divisor = div_reg;

  assign edge_now      = (state_reg == USP_SHIFT) && (half_cnt_reg == div_reg);
  assign half_cnt_next = (state_reg != USP_SHIFT || edge_now) ? HALF_CNT_RESET
                                                              : half_cnt_reg + HALF_CNT_STEP;
  assign lead_edge  = edge_now && !edge_cnt_reg[0];
  assign trail_edge = edge_now && edge_cnt_reg[0];
  assign frame_end  = edge_now && (edge_cnt_reg == LAST_EDGE);
  assign sample_now = cfg.clock_phase_bit ? trail_edge : lead_edge;
  assign setup_now  = cfg.clock_phase_bit ? lead_edge : (trail_edge && !frame_end);
  // load when shifter free; back to back
  assign load_now   = fifo_out_valid && spi_on && (state_reg == USP_IDLE || frame_end);
  assign txc_set    = frame_end && !load_now;

  // shared transfer controller
  always_comb begin
    state_next = state_reg;
    if (!spi_on) state_next = USP_IDLE;
    else if (load_now) state_next = USP_SHIFT;
    else if (frame_end) state_next = USP_IDLE;
  end

  // state and clock generator
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= USP_IDLE;
      half_cnt_reg  <= HALF_CNT_RESET;
      edge_cnt_reg  <= EDGE_CNT_RESET;
      sck_phase_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      half_cnt_reg  <= half_cnt_next;
      if (!spi_on || load_now) edge_cnt_reg <= EDGE_CNT_RESET;
      else if (edge_now) edge_cnt_reg <= edge_cnt_reg + 4'h1;
      if (!spi_on) sck_phase_reg <= 1'b0;
      else if (edge_now) sck_phase_reg <= !sck_phase_reg;
    end
  end

  assign rx_sh_next = !sample_now ? rx_sh_reg :
                      cfg.data_order_bit ? {sync2_reg, rx_sh_reg[FRAME_BITS-1:1]}
                                         : {rx_sh_reg[FRAME_BITS-2:0], sync2_reg};

  // shifters and data line
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
      out_reg   <= IDLE_LINE;
    end else begin
      rx_sh_reg <= rx_sh_next;
      if (load_now) begin
        tx_sh_reg <= cfg.clock_phase_bit ? fifo_out_data
                                         : shift_on(fifo_out_data, cfg.data_order_bit);
        if (!cfg.clock_phase_bit) out_reg <= first_bit(fifo_out_data, cfg.data_order_bit);
      end else if (setup_now) begin
        tx_sh_reg <= shift_on(tx_sh_reg, cfg.data_order_bit);
        out_reg   <= first_bit(tx_sh_reg, cfg.data_order_bit);
      end else if (!spi_on || frame_end) begin
        out_reg <= IDLE_LINE;
      end
    end
  end

  // input pin synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= serial_data_in;
      sync2_reg <= sync1_reg;
    end
  end

  // receive buffer, newest dropped when full
  assign rx_push  = frame_end && receiver_enable_bit;
  assign rx_pop   = rx_ready && rx_valid;
  assign rx_valid = (rx_count_reg != RX_COUNT_EMPTY);
  assign rx_data  = rx_buf_reg[0];

  always_ff @(posedge clk) begin
    if (reset || !receiver_enable_bit) begin
      rx_count_reg <= RX_COUNT_EMPTY;
    end else if (rx_push && (rx_count_reg != RX_COUNT_FULL || rx_pop)) begin
      if (!rx_pop) rx_count_reg <= rx_count_reg + RX_COUNT_STEP;
    end else if (rx_pop) begin
      rx_count_reg <= rx_count_reg - RX_COUNT_STEP;
    end
  end

  // buffer entries move toward the head on a read
  always_ff @(posedge clk) begin
    if (rx_pop) rx_buf_reg[0] <= rx_buf_reg[1];
    if (rx_push && (rx_count_reg != RX_COUNT_FULL || rx_pop)) begin
      if (rx_count_reg == RX_COUNT_EMPTY || (rx_pop && rx_count_reg == RX_COUNT_STEP))
        rx_buf_reg[0] <= rx_sh_next;
      else
        rx_buf_reg[1] <= rx_sh_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) txc_reg <= 1'b0;
    else if (txc_set) txc_reg <= 1'b1;
    else if (transmit_complete_clear) txc_reg <= 1'b0;
  end
  assign transmit_complete_flag = txc_reg;

  assign frame_error_flag  = 1'b0;
  assign overrun_flag      = 1'b0;
  assign parity_error_flag = 1'b0;

  // clock always generated; pin driven only with pin direction set; polarity sets rest level
  assign transfer_clock_pin_out = sck_phase_reg ^ cfg.clock_polarity_bit;
  // pin control as in normal modes
  assign transfer_clock_pin_oe  = clock_pin_direction && master_spi_mode;
  assign serial_data_out        = out_reg;
  assign serial_data_oe         = spi_on;

  property p_sck_rest;
    @(posedge clk) disable iff (reset)
      (state_reg == USP_IDLE) |-> (transfer_clock_pin_out == cfg.clock_polarity_bit);
  endproperty
  a_sck_rest: assert property (p_sck_rest) else $error("clock not at rest level");

  property p_fast_clock;
    @(posedge clk) disable iff (reset)
      (edge_now && !frame_end && div_reg == DIV_RESET && spi_on) |=> edge_now;
  endproperty
  a_fast_clock: assert property (p_fast_clock) else $error("divisor zero edge missed");

  property p_div_one;
    @(posedge clk) disable iff (reset)
      (edge_now && !frame_end && div_reg == 12'h001 && spi_on && !baud_divisor_we)
        |=> !edge_now ##1 edge_now;
  endproperty
  a_div_one: assert property (p_div_one) else $error("half period wrong for divisor one");

  property p_line_idle;
    @(posedge clk) disable iff (reset)
      (state_reg == USP_IDLE && $past(state_reg) == USP_IDLE) |-> serial_data_out;
  endproperty
  a_line_idle: assert property (p_line_idle) else $error("data line not idle high");

  property p_txc_empty;
    @(posedge clk) disable iff (reset)
      $rose(transmit_complete_flag) |-> $past(frame_end) && !$past(fifo_out_valid && spi_on);
  endproperty
  a_txc_empty: assert property (p_txc_empty) else $error("complete raised too early");

  property p_no_errors;
    @(posedge clk) disable iff (reset)
      !(frame_error_flag || overrun_flag || parity_error_flag);
  endproperty
  a_no_errors: assert property (p_no_errors) else $error("error flag set");

  property p_mode_off;
    @(posedge clk) disable iff (reset)
      !spi_on |=> (state_reg == USP_IDLE);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("shifting while not in spi mode");

  property p_overflow_keep;
    @(posedge clk) disable iff (reset)
      (rx_count_reg == RX_COUNT_FULL && rx_push && !rx_pop && receiver_enable_bit)
        |=> (rx_count_reg == RX_COUNT_FULL) && $stable(rx_data);
  endproperty
  a_overflow_keep: assert property (p_overflow_keep) else $error("older byte lost");

  property p_div_reset;
    @(posedge clk) reset |=> (baud_divisor == DIV_RESET);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor not zero after reset");

  property p_sample_edge;
    @(posedge clk) disable iff (reset)
      sample_now |-> ((transfer_clock_pin_out ^ cfg.clock_polarity_bit) == cfg.clock_phase_bit);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sampled on wrong edge");

  property p_set_wins;
    @(posedge clk) disable iff (reset)
      txc_set |=> transmit_complete_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("complete event lost");
endmodule : usp_master
`default_nettype wire
